// File: design/pfm_pkg.sv
package pfm_pkg;

  // ----------------------------------------------------------------
  // Register map, word indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_PLL_WATCH = 10'h0C5;
  localparam logic [9:0] IDX_FAULT_CTRL = 10'h0C6;
  localparam logic [9:0] IDX_FAULT_STAT = 10'h0C7;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h0C8;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0C9;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NUM_FAULTS = 4;
  localparam int FC_LEVEL_LSB = 12;
  localparam int FC_AUTO_LSB = 8;
  localparam int FC_SAFE_LSB = 4;
  localparam int FC_FIE_LSB = 0;
  localparam int FS_FLAG_LSB = 0;
  localparam int FS_FULL_LSB = 4;
  localparam int FS_PIN_LSB = 8;
  localparam int IRQ_FAULT_LSB = 0;
  localparam int IRQ_PLL_BIT = 4;
  localparam int IRQ_START_BIT = 5;
  localparam int IRQ_W = 6;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] PLL_WATCH_RST = 2'h0;
  localparam logic [15:0] FAULT_CTRL_RST = 16'h0000;
  localparam logic [3:0] FULL_SEL_RST = 4'h0;
  localparam logic [5:0] IRQ_RST = 6'h00;
  localparam int PW_MON_BIT = 0;
  localparam int PW_LOCK_BIT = 1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int STARTUP_NS = 25000;
  localparam int STARTUP_CYC = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] STARTUP_CNT = 10'(STARTUP_CYC);
  localparam logic [1:0] FILT_SAMPLES = 2'h3;

  typedef enum logic [2:0] {
    PFM_FD_RUN = 3'b001,
    PFM_FD_OFF = 3'b010,
    PFM_FD_START = 3'b100
  } pfm_fd_state_t;

endpackage : pfm_pkg

// File: design/pfm_fault_if.sv
`timescale 1ns/1ps
interface pfm_fault_if;
  logic [3:0] rawSync;
  logic [3:0] level;
  logic [3:0] autoClear;
  logic [3:0] safety;
  logic [3:0] fullSel;
  logic [3:0] flagClear;
  logic halfStart;
  logic fullStart;
  wire [3:0] filtered;
  wire [3:0] flag;
  wire [3:0] disable_;
  wire [3:0] faultEvent;

  modport ctrl (
    output rawSync, level, autoClear, safety, fullSel, flagClear, halfStart, fullStart,
    input filtered, flag, disable_, faultEvent
  );
  modport chan (
    input rawSync, level, autoClear, safety, fullSel, flagClear, halfStart, fullStart,
    output filtered, flag, disable_, faultEvent
  );
endinterface : pfm_fault_if

// File: design/pfm_sync.sv
`timescale 1ns/1ps
module pfm_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      dout <= '0;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : pfm_sync

// File: design/pfm_fault_chan.sv
`timescale 1ns/1ps
module pfm_fault_chan #(
  parameter int IDX = 0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  pfm_fault_if.chan bus
);
  logic active;
  logic filt_reg;
  logic [1:0] filtCnt_reg;
  logic filtPrev_reg;
  logic flag_reg;
  logic dis_reg;
  logic cycleStart;
  logic clearOk;

  assign active = bus.level[IDX] ? bus.rawSync[IDX] : ~bus.rawSync[IDX];

  // Only the counter resets, so an unknown filtered level settles
  // after three samples while reset leaves a known level untouched
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      filtCnt_reg <= 2'h0;
    end else if (active == filt_reg) begin
      filtCnt_reg <= 2'h0;
    end else if (filtCnt_reg == pfm_pkg::FILT_SAMPLES - 2'h1) begin
      filtCnt_reg <= 2'h0;
    end else begin
      filtCnt_reg <= filtCnt_reg + 2'h1;
    end
  end

  // Filtered level is deliberately left out of reset
  always_ff @(posedge ref_clk) begin
    if (active == filt_reg) begin
      filt_reg <= filt_reg;
    end else if (filtCnt_reg == pfm_pkg::FILT_SAMPLES - 2'h1) begin
      filt_reg <= active;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      filtPrev_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      filtPrev_reg <= filt_reg;
      if (filt_reg) begin
        flag_reg <= 1'b1;
      end else if (bus.flagClear[IDX]) begin
        flag_reg <= 1'b0;
      end
    end
  end

  assign cycleStart = bus.fullSel[IDX] ? bus.fullStart : (bus.halfStart | bus.fullStart);
  assign clearOk = bus.autoClear[IDX] ? ~filt_reg
                 : (~flag_reg & (~bus.safety[IDX] | ~filt_reg));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dis_reg <= 1'b0;
    end else if (filt_reg) begin
      dis_reg <= 1'b1;
    end else if (cycleStart && clearOk) begin
      dis_reg <= 1'b0;
    end
  end

  assign bus.filtered[IDX] = filt_reg;
  assign bus.flag[IDX] = flag_reg;
  assign bus.disable_[IDX] = dis_reg;
  assign bus.faultEvent[IDX] = filt_reg & ~filtPrev_reg;
endmodule : pfm_fault_chan

// File: design/pfm_fault_pll_monitor.sv
// Contract
// - Bits 15..2 of PLL watch control read zero, writes ignored.
// - With watching on, hold fractional delay off while PLL lock or reference lost.
// - On PLL recovery, fractional delay runs a 25 us startup before use.
// - Select 00 means no watching, 01 means watching; neither locks.
// - Select 10 or 11 locks the field against writes until reset.
// - One active-level bit per fault input; 0 low is fault, 1 high.
// - One clearing-mode bit per fault input, reset zero, manual or automatic.
// - Manual clearing re-enables only when latched flag clear at cycle start.
// - Automatic clearing re-enables when filtered state clear, flag ignored.
// - Manual safe mode also requires filtered state clear at cycle start.
// - Filtered state shown active high, untouched by reset.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
module pfm_fault_pll_monitor (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] faultInput,
  input wire logic pllLocked,
  input wire logic pllRefPresent,
  input wire logic halfCycleStart,
  input wire logic fullCycleStart,
  input wire logic [3:0] fracDelayPowerUp,
  output logic [3:0] fracDelayRun,
  output logic fracStartupBusy,
  output logic [3:0] outputDisable,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] pllWatch_reg;
  logic [15:0] faultCtrl_reg;
  logic [3:0] fullSel_reg;
  logic [5:0] irqStat_reg;
  logic [5:0] irqMask_reg;
  logic [5:0] irqSet;
  logic ack_reg;
  logic [31:0] rdData;
  logic [9:0] wordIdx;
  logic access;
  logic wrStrobe;
  logic rdStrobe;
  logic [3:0] faultSync;
  logic [1:0] pllSync;
  logic pllProblem;
  logic pllProblemPrev_reg;
  logic pllProblemRise;
  logic monitorOn;
  pfm_pkg::pfm_fd_state_t fdState_reg;
  pfm_pkg::pfm_fd_state_t fdState_next;
  logic [9:0] startCnt_reg;
  logic [3:0] puPrev_reg;
  logic puRise;
  logic startDone;
  logic startEntry;

  pfm_fault_if fbus ();

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  pfm_sync #(
    .W(4)
  ) u_fault_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din(faultInput),
    .dout(faultSync)
  );

  // Lock and reference come from the PLL's own domain
  pfm_sync #(
    .W(2)
  ) u_pll_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din({pllRefPresent, pllLocked}),
    .dout(pllSync)
  );

  assign pllProblem = ~(pllSync[0] & pllSync[1]);

  // ----------------------------------------------------------------
  // PLL problem edge
  // ----------------------------------------------------------------
  // Synchronisers reset low, which reads as a problem; starting the
  // history high keeps reset itself from posting a problem event
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pllProblemPrev_reg <= 1'b1;
    end else begin
      pllProblemPrev_reg <= pllProblem;
    end
  end

  assign pllProblemRise = pllProblem & ~pllProblemPrev_reg;

  // ----------------------------------------------------------------
  // Fault channels
  // ----------------------------------------------------------------
  assign fbus.rawSync = faultSync;
  assign fbus.level = faultCtrl_reg[pfm_pkg::FC_LEVEL_LSB +: 4];
  assign fbus.autoClear = faultCtrl_reg[pfm_pkg::FC_AUTO_LSB +: 4];
  assign fbus.safety = faultCtrl_reg[pfm_pkg::FC_SAFE_LSB +: 4];
  assign fbus.fullSel = fullSel_reg;
  assign fbus.halfStart = halfCycleStart;
  assign fbus.fullStart = fullCycleStart;

  // Writing one to a latched flag clears it
  assign fbus.flagClear = (wrStrobe && wordIdx == pfm_pkg::IDX_FAULT_STAT && wb_sel_i[0])
                        ? wb_dat_i[pfm_pkg::FS_FLAG_LSB +: 4] : 4'h0;

  for (genvar i = 0; i < pfm_pkg::NUM_FAULTS; i++) begin : g_chan
    pfm_fault_chan #(
      .IDX(i)
    ) u_chan (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .bus(fbus)
    );
  end

  assign outputDisable = fbus.disable_;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // One wait state: ack follows the request by one edge, write lands
  // on the edge the master sees ack.
  assign wordIdx = wb_adr_i[11:2];
  assign access = wb_cyc_i & wb_stb_i & ack_reg;
  assign wrStrobe = access & wb_we_i;
  assign rdStrobe = access & ~wb_we_i;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
    end
  end

  assign wb_ack_o = ack_reg;

  // Unmapped words read zero and ignore writes
  always_comb begin
    rdData = 32'h0000_0000;
    case (wordIdx)
      pfm_pkg::IDX_PLL_WATCH: begin
        rdData[1:0] = pllWatch_reg;
      end
      pfm_pkg::IDX_FAULT_CTRL: begin
        rdData[15:0] = faultCtrl_reg;
      end
      pfm_pkg::IDX_FAULT_STAT: begin
        rdData[pfm_pkg::FS_FLAG_LSB +: 4] = fbus.flag;
        rdData[pfm_pkg::FS_FULL_LSB +: 4] = fullSel_reg;
        rdData[pfm_pkg::FS_PIN_LSB +: 4] = fbus.filtered;
      end
      pfm_pkg::IDX_IRQ_STAT: begin
        rdData[5:0] = irqStat_reg;
      end
      pfm_pkg::IDX_IRQ_MASK: begin
        rdData[5:0] = irqMask_reg;
      end
      default: begin
        rdData = 32'h0000_0000;
      end
    endcase
  end

  // Data captured when the request is first seen, before any read clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      wb_dat_o <= rdData;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Lock bit set means the select is frozen until the next reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pllWatch_reg <= pfm_pkg::PLL_WATCH_RST;
    end else if (wrStrobe && wordIdx == pfm_pkg::IDX_PLL_WATCH && wb_sel_i[0]) begin
      if (!pllWatch_reg[pfm_pkg::PW_LOCK_BIT]) begin
        pllWatch_reg <= wb_dat_i[1:0];
      end
    end
  end

  assign monitorOn = pllWatch_reg[pfm_pkg::PW_MON_BIT];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      faultCtrl_reg <= pfm_pkg::FAULT_CTRL_RST;
    end else if (wrStrobe && wordIdx == pfm_pkg::IDX_FAULT_CTRL) begin
      if (wb_sel_i[0]) begin
        faultCtrl_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        faultCtrl_reg[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fullSel_reg <= pfm_pkg::FULL_SEL_RST;
    end else if (wrStrobe && wordIdx == pfm_pkg::IDX_FAULT_STAT && wb_sel_i[0]) begin
      fullSel_reg <= wb_dat_i[pfm_pkg::FS_FULL_LSB +: 4];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irqMask_reg <= pfm_pkg::IRQ_RST;
    end else if (wrStrobe && wordIdx == pfm_pkg::IDX_IRQ_MASK && wb_sel_i[0]) begin
      irqMask_reg <= wb_dat_i[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Fractional delay watch
  // ----------------------------------------------------------------
  // A rising power-up bit restarts the whole delay block; a single
  // shared timer is cheaper than one per submodule.
  // Power-up history resets low, so a rise seen during the reset
  // startup is ignored there rather than restarting it
  assign puRise = |(fracDelayPowerUp & ~puPrev_reg);
  assign startDone = (fdState_reg == pfm_pkg::PFM_FD_START) && (startCnt_reg == 10'h001);
  assign startEntry = (fdState_next == pfm_pkg::PFM_FD_START)
                      && (fdState_reg != pfm_pkg::PFM_FD_START);

  always_comb begin
    fdState_next = fdState_reg;
    case (fdState_reg)
      pfm_pkg::PFM_FD_RUN: begin
        if (monitorOn && pllProblem) begin
          fdState_next = pfm_pkg::PFM_FD_OFF;
        end else if (puRise) begin
          fdState_next = pfm_pkg::PFM_FD_START;
        end
      end
      pfm_pkg::PFM_FD_OFF: begin
        if (!pllProblem) begin
          fdState_next = pfm_pkg::PFM_FD_START;
        end
      end
      pfm_pkg::PFM_FD_START: begin
        if (monitorOn && pllProblem) begin
          fdState_next = pfm_pkg::PFM_FD_OFF;
        end else if (startDone) begin
          fdState_next = pfm_pkg::PFM_FD_RUN;
        end
      end
      default: begin
        fdState_next = pfm_pkg::PFM_FD_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fdState_reg <= pfm_pkg::PFM_FD_START;
    end else begin
      fdState_reg <= fdState_next;
    end
  end

  // Timer reloads on every entry to startup. After reset the state is
  // already startup while busy is still low, so one extra count keeps
  // the busy span at the full startup length.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      startCnt_reg <= pfm_pkg::STARTUP_CNT + 10'h001;
    end else if (startEntry) begin
      startCnt_reg <= pfm_pkg::STARTUP_CNT;
    end else if (fdState_reg == pfm_pkg::PFM_FD_START && startCnt_reg != 10'h000) begin
      startCnt_reg <= startCnt_reg - 10'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      puPrev_reg <= 4'h0;
    end else begin
      puPrev_reg <= fracDelayPowerUp;
    end
  end

  // Without watching, software must cycle the power-up bits itself
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fracDelayRun <= 4'h0;
      fracStartupBusy <= 1'b0;
    end else begin
      fracDelayRun <= (fdState_next == pfm_pkg::PFM_FD_RUN) ? fracDelayPowerUp : 4'h0;
      fracStartupBusy <= (fdState_next == pfm_pkg::PFM_FD_START);
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irqSet[pfm_pkg::IRQ_FAULT_LSB +: 4] = fbus.faultEvent
                                             & faultCtrl_reg[pfm_pkg::FC_FIE_LSB +: 4];
  assign irqSet[pfm_pkg::IRQ_PLL_BIT] = pllProblemRise;
  assign irqSet[pfm_pkg::IRQ_START_BIT] = startDone;

  // Set beats the read clear so only an event set on the edge that captures the read data is lost
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irqStat_reg <= pfm_pkg::IRQ_RST;
    end else if (rdStrobe && wordIdx == pfm_pkg::IDX_IRQ_STAT) begin
      irqStat_reg <= irqSet;
    end else begin
      irqStat_reg <= irqStat_reg | irqSet;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irqStat_reg | irqSet) & irqMask_reg);
    end
  end

endmodule : pfm_fault_pll_monitor

// File: tb/pfm_fault_pll_monitor_asserts.sv
`timescale 1ns/1ps
module pfm_fault_pll_monitor_asserts (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pllLocked,
  input wire logic pllRefPresent,
  input wire logic halfCycleStart,
  input wire logic fullCycleStart,
  input wire logic [3:0] fracDelayRun,
  input wire logic fracStartupBusy,
  input wire logic [3:0] outputDisable
);
  // ----
  // Shadow of the watch select, frozen once bit 1 is set
  // ----
  logic [1:0] monSel;
  logic [9:0] busyCnt;
  logic wrPll;
  assign wrPll = wb_ack_o && wb_we_i && wb_sel_i[0]
    && wb_adr_i[11:2] == pfm_pkg::IDX_PLL_WATCH;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      monSel <= 2'h0;
    end else if (wrPll && !monSel[1]) begin
      monSel <= wb_dat_i[1:0];
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busyCnt <= 10'h000;
    end else begin
      busyCnt <= fracStartupBusy ? busyCnt + 10'h001 : 10'h000;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rdPll;
    wb_ack_o && !wb_we_i && wb_adr_i[11:2] == pfm_pkg::IDX_PLL_WATCH;
  endsequence
  sequence s_pllBad;
    (monSel[0] && !(pllLocked && pllRefPresent))[*6];
  endsequence
  property p_ackAnswer;
    s_req |=> wb_ack_o;
  endproperty
  a_ackAnswer: assert property (p_ackAnswer) else $error("request not acked next cycle");
  property p_ackPulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
  property p_pllRsvd;
    s_rdPll |-> wb_dat_o[31:2] == 30'h0;
  endproperty
  a_pllRsvd: assert property (p_pllRsvd) else $error("watch upper bits not zero");
  property p_pllSel;
    s_rdPll |-> wb_dat_o[1:0] == monSel;
  endproperty
  a_pllSel: assert property (p_pllSel) else $error("watch select wrong");
  property p_monOff;
    s_pllBad |-> fracDelayRun == 4'h0;
  endproperty
  a_monOff: assert property (p_monOff) else $error("delay runs on bad PLL");
  property p_startLen;
    $fell(fracStartupBusy) |-> busyCnt == pfm_pkg::STARTUP_CNT;
  endproperty
  a_startLen: assert property (p_startLen) else $error("startup length wrong");
  property p_busyIdle;
    fracStartupBusy |-> fracDelayRun == 4'h0;
  endproperty
  a_busyIdle: assert property (p_busyIdle) else $error("delay runs in startup");
  property p_disClear;
    |($past(outputDisable) & ~outputDisable) |-> $past(halfCycleStart || fullCycleStart)
      || $past(halfCycleStart || fullCycleStart, 2);
  endproperty
  a_disClear: assert property (p_disClear) else $error("disable cleared off cycle start");
endmodule : pfm_fault_pll_monitor_asserts
bind pfm_fault_pll_monitor pfm_fault_pll_monitor_asserts i_chk (.ref_clk, .nrst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pllLocked,
  .pllRefPresent, .halfCycleStart, .fullCycleStart, .fracDelayRun, .fracStartupBusy,
  .outputDisable);

// File: tb/pfm_partner_model.sv
`timescale 1ns/1ps
module pfm_partner_model (
  input wire logic ref_clk,
  input wire logic [3:0] faultCmd,
  input wire logic pllOk,
  input wire logic refOk,
  output logic [3:0] faultInput,
  output logic pllLocked,
  output logic pllRefPresent
);
  // Pins follow the command one clock late; lock and reference fail independently
  initial begin
    faultInput = 4'hF;
    pllLocked = 1'b1;
    pllRefPresent = 1'b1;
  end
  always @(posedge ref_clk) begin
    faultInput <= faultCmd;
    pllLocked <= pllOk;
    pllRefPresent <= refOk;
  end
endmodule : pfm_partner_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pllOk, refOk, irq;
  logic pllLocked, pllRefPresent, halfCycleStart, fullCycleStart, fracStartupBusy;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i, faultCmd, faultInput, fracDelayPowerUp, fracDelayRun, outputDisable;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int n_fail = 0;
  int check_count = 0;
  always #20 ref_clk = ~ref_clk;
  pfm_fault_pll_monitor i_dut (.ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .faultInput, .pllLocked, .pllRefPresent,
    .halfCycleStart, .fullCycleStart, .fracDelayPowerUp, .fracDelayRun, .fracStartupBusy,
    .outputDisable, .irq);
  pfm_partner_model i_far (.ref_clk, .faultCmd, .pllOk, .refOk, .faultInput, .pllLocked,
    .pllRefPresent);
  // ----
  // Helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic waitClk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : waitClk
  task automatic bus(input logic we, input logic [9:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {16'h0000, d};
    wb_sel_i <= 4'h3;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (n >= 50) n_fail++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic rdChk(input logic [9:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 16'h0000);
    chk(rd, exp);
  endtask : rdChk
  task automatic pulse(input logic full);
    if (full) fullCycleStart <= 1'b1;
    else halfCycleStart <= 1'b1;
    @(posedge ref_clk);
    fullCycleStart <= 1'b0;
    halfCycleStart <= 1'b0;
    waitClk(3);
  endtask : pulse
  task automatic waitIdle;
    int n;
    n = 0;
    waitClk(4);
    while (fracStartupBusy !== 1'b0 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 1000) n_fail++;
  endtask : waitIdle
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    rdChk(pfm_pkg::IDX_PLL_WATCH, 32'h0);
    rdChk(pfm_pkg::IDX_FAULT_CTRL, 32'h0);
    bus(1'b1, pfm_pkg::IDX_FAULT_CTRL, 16'h0FF0);
    rdChk(pfm_pkg::IDX_FAULT_CTRL, 32'h0FF0);
    bus(1'b1, pfm_pkg::IDX_FAULT_CTRL, 16'h0000);
    bus(1'b1, 10'h3FF, 16'hFFFF);
    rdChk(10'h3FF, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_soft;
    waitIdle();
    chk(32'(fracDelayRun), 32'hF);
    pllOk <= 1'b0;
    waitClk(10);
    chk(32'(fracDelayRun), 32'hF);
    pllOk <= 1'b1;
    waitClk(5);
    fracDelayPowerUp <= 4'h0;
    waitClk(2);
    fracDelayPowerUp <= 4'hF;
    waitClk(3);
    chk(32'(fracStartupBusy), 32'h1);
    waitIdle();
    chk(32'(fracDelayRun), 32'hF);
    $display("test soft restart done");
  endtask : t_soft
  task automatic t_mon;
    bus(1'b1, pfm_pkg::IDX_PLL_WATCH, 16'hFFFD);
    rdChk(pfm_pkg::IDX_PLL_WATCH, 32'h1);
    for (int k = 0; k < 2; k++) begin
      pllOk <= (k != 0);
      refOk <= (k == 0);
      waitClk(10);
      chk(32'(fracDelayRun), 32'h0);
      pllOk <= 1'b1;
      refOk <= 1'b1;
      waitClk(6);
      chk(32'(fracStartupBusy), 32'h1);
      waitIdle();
      chk(32'(fracDelayRun), 32'hF);
    end
    $display("test monitor done");
  endtask : t_mon
  task automatic t_lock;
    for (int v = 2; v < 4; v++) begin
      bus(1'b1, pfm_pkg::IDX_PLL_WATCH, 16'(v));
      bus(1'b1, pfm_pkg::IDX_PLL_WATCH, 16'h0001);
      rdChk(pfm_pkg::IDX_PLL_WATCH, 32'(v));
      nrst <= 1'b0;
      waitClk(4);
      nrst <= 1'b1;
      waitClk(1);
      rdChk(pfm_pkg::IDX_PLL_WATCH, 32'h0);
      waitIdle();
    end
    $display("test lock done");
  endtask : t_lock
  task automatic t_fault;
    logic [3:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 4'h1 << i;
      faultCmd <= ~m;
      waitClk(10);
      chk(32'(outputDisable), 32'(m));
      rdChk(pfm_pkg::IDX_FAULT_STAT, {20'h0, m, 4'h0, m});
      faultCmd <= 4'hF;
      waitClk(10);
      pulse(1'b0);
      chk(32'(outputDisable), 32'(m));
      bus(1'b1, pfm_pkg::IDX_FAULT_STAT, {12'h000, m});
      pulse(1'b1);
      chk(32'(outputDisable), 32'h0);
    end
    faultCmd <= 4'h0;
    bus(1'b1, pfm_pkg::IDX_FAULT_CTRL, 16'hFF00);
    waitClk(10);
    pulse(1'b0);
    chk(32'(outputDisable), 32'h0);
    for (int i = 0; i < 4; i++) begin
      m = 4'h1 << i;
      faultCmd <= m;
      waitClk(10);
      chk(32'(outputDisable), 32'(m));
      faultCmd <= 4'h0;
      waitClk(10);
      chk(32'(outputDisable), 32'(m));
      pulse(1'b0);
      chk(32'(outputDisable), 32'h0);
    end
    bus(1'b1, pfm_pkg::IDX_FAULT_CTRL, 16'hF0F0);
    bus(1'b1, pfm_pkg::IDX_FAULT_STAT, 16'h00FF);
    faultCmd <= 4'h1;
    waitClk(10);
    bus(1'b1, pfm_pkg::IDX_FAULT_STAT, 16'h00F1);
    pulse(1'b1);
    chk(32'(outputDisable), 32'h1);
    faultCmd <= 4'h0;
    waitClk(10);
    bus(1'b1, pfm_pkg::IDX_FAULT_STAT, 16'h00F1);
    pulse(1'b0);
    chk(32'(outputDisable), 32'h1);
    pulse(1'b1);
    chk(32'(outputDisable), 32'h0);
    $display("test fault done");
  endtask : t_fault
  task automatic t_irq;
    bus(1'b1, pfm_pkg::IDX_FAULT_CTRL, 16'hF001);
    bus(1'b1, pfm_pkg::IDX_IRQ_MASK, 16'h0001);
    bus(1'b0, pfm_pkg::IDX_IRQ_STAT, 16'h0000);
    faultCmd <= 4'h1;
    waitClk(10);
    chk(32'(irq), 32'h1);
    rdChk(pfm_pkg::IDX_IRQ_STAT, 32'h1);
    waitClk(2);
    chk(32'(irq), 32'h0);
    bus(1'b1, pfm_pkg::IDX_IRQ_MASK, 16'h0000);
    faultCmd <= 4'h0;
    waitClk(10);
    faultCmd <= 4'h1;
    waitClk(10);
    chk(32'(irq), 32'h0);
    rdChk(pfm_pkg::IDX_IRQ_STAT, 32'h1);
    $display("test irq done");
  endtask : t_irq
  // Generous bound: each startup is 625 cycles and there are six of them
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_fail++;
    print_verdict();
  end
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, halfCycleStart, fullCycleStart} = 5'h00;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    faultCmd = 4'hF;
    pllOk = 1'b1;
    refOk = 1'b1;
    fracDelayPowerUp = 4'hF;
    waitClk(4);
    nrst <= 1'b1;
    waitClk(1);
    t_regs();
    t_soft();
    t_mon();
    t_lock();
    t_fault();
    t_irq();
    print_verdict();
  end
endmodule : tb_top
